// ===== src/aidsc_top.v
// Accessory sense decode, host report and switch configuration
`default_nettype none
// Functional notes
// - Watch sense code for attach and detach, report known type with interrupt.
// - Any change of sense code updates the converter value register.
// - Switch wait timer starts only after host reads the event register.
// - Code 0 OTG host, code 1 call-end key, codes 2-13 buttons 1-12.
// - Code 24 factory USB boot off, code 25 factory USB boot on.
// - Code 28 factory serial boot off, code 29 factory serial boot on.
// - Code 30 is type-1 audio, with remote or call-end only.
// - Code 31 open: USB, USB charger, dedicated charger or detach, told by charger detect.
// - Charger codes reported only while bus supply is valid.
// - Type-1 audio sets audio flag and configures audio switching.
// - Selector has host, audio, video, serial and teletype throws, under register control only in the configure state.
// - USB routes host pair, bypass, FET closed; chargers pull charge-rate low.
// - Audio, serial, teletype and video cable routes per accessory.
// - Factory cables drive power-up low, startup select per boot variant.
// - Non-factory: select low, power-up released; FET follows supply for some.
// - Unrouted sense pin keeps being converted; code change is a state change.
// - Video cable charge-rate released unless supply valid, then driven low.
// - Any detected charger pulls charge-rate low.
// - Factory cables configure at once, no acknowledge, no wait timer.
`include "aidsc_consts.vh"
module aidsc_top (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire [4:0]  sense_code_in,
    input  wire        vbus_valid_in,
    input  wire        usb_charger_in,
    input  wire        ded_charger_in,
    input  wire [3:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [15:0] reg_rdata_out,
    output wire        irq_n_out,
    output reg  [2:0]  data_route_out,
    output reg  [1:0]  sense_route_out,
    output reg         voice_input_path_out,
    output reg         fet_closed_out,
    output reg         startup_select_out,
    output reg         factory_pwr_o_out,
    output reg         factory_pwr_oe_n_out,
    output reg         charge_rate_signal_o_out,
    output reg         charge_rate_signal_oe_n_out
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ACK  = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_CONF = 4'b1000;

    // ************************************************
    // Input synchronisers
    // ************************************************
    reg [4:0] code_m_q, code_s_q, code_q;
    reg [2:0] lvl_m_q, lvl_s_q;
    wire      vbus_s  = lvl_s_q[0];
    wire      usbc_s  = lvl_s_q[1];
    wire      dedc_s  = lvl_s_q[2];
    always @(posedge mclk_in) begin
        code_m_q <= sense_code_in;
        code_s_q <= code_m_q;
        lvl_m_q  <= {ded_charger_in, usb_charger_in, vbus_valid_in};
        lvl_s_q  <= lvl_m_q;
    end

    // ************************************************
    // Code classification
    // ************************************************
    function [12:0] aidsc_classify;
        input [4:0] c;
        input       vb, uc, dc;
        reg   [12:0] t;
        begin
            t = 13'h0000;
            if (c == `AIDSC_CODE_OTG) t[`AIDSC_DT_OTG] = 1'b1;
            else if (c >= `AIDSC_CODE_RSV_LO && c <= `AIDSC_CODE_RSV_HI) t[`AIDSC_DT_RESERVED] = 1'b1;
            else case (c)
                `AIDSC_CODE_AUDIO2:   t[`AIDSC_DT_AUDIO2] = 1'b1;
                `AIDSC_CODE_PPD:      t[`AIDSC_DT_PPD]    = 1'b1;
                `AIDSC_CODE_TTY:      t[`AIDSC_DT_TTY]    = 1'b1;
                `AIDSC_CODE_SERIAL:   t[`AIDSC_DT_SERIAL] = 1'b1;
                `AIDSC_CODE_CHG1,
                `AIDSC_CODE_CHG2:     t[`AIDSC_DT_CHARGER] = vb;
                `AIDSC_CODE_FUSB_OFF,
                `AIDSC_CODE_FUSB_ON,
                `AIDSC_CODE_FSER_OFF,
                `AIDSC_CODE_FSER_ON:  t[`AIDSC_DT_FACTORY] = 1'b1;
                `AIDSC_CODE_AV:       t[`AIDSC_DT_AV]     = 1'b1;
                `AIDSC_CODE_AUDIO1:   t[`AIDSC_DT_AUDIO1] = 1'b1;
                `AIDSC_CODE_OPEN: begin
                    t[`AIDSC_DT_USBCHG] = vb & uc;
                    t[`AIDSC_DT_DEDCHG] = vb & dc & ~uc;
                    t[`AIDSC_DT_USB]    = vb & ~uc & ~dc;
                end
                default:              t = 13'h0000;
            endcase
            aidsc_classify = t;
        end
    endfunction

    // Charger detect levels only count on an open sense pin
    wire [12:0] type_now  = aidsc_classify(code_s_q, vbus_s, usbc_s, dedc_s);
    // Button codes are presses during audio, not a new accessory
    wire        is_button = (code_s_q >= `AIDSC_CODE_SENDEND) && (code_s_q <= `AIDSC_CODE_BTN_HI);
    wire        is_fact   = type_now[`AIDSC_DT_FACTORY];
    wire        attached  = |type_now;

    // ************************************************
    // Registers and detection sequence
    // ************************************************
    reg [3:0]  state_q;
    reg [12:0] dev_type_q;
    reg [3:0]  event_q;
    reg        irq_mask_q;
    reg        manual_q;
    reg [7:0]  wait_units_q;
    reg [2:0]  man_route_q;
    reg [7:0]  unit_cnt_q;
    reg [15:0] div_cnt_q;
    reg        changed_q;
    reg [2:0]  lvl_q;
    wire       rd_event = reg_rd_in && (reg_addr_in == `AIDSC_REG_EVENT);
    wire       unit_tick = (div_cnt_q == `AIDSC_WAIT_UNIT_CYC - 1);
    wire       code_chg  = (code_s_q != code_q);
    // Supply or charger change on a steady code can still change the type
    wire       lvl_chg   = (lvl_s_q != lvl_q) && (type_now != dev_type_q) && !is_button;
    wire [3:0] ev_set;

    // Detach needs a reported type; a charger code without supply raises only the change event
    assign ev_set[`AIDSC_EV_ATTACH] = changed_q && attached && !is_button;
    assign ev_set[`AIDSC_EV_DETACH] = changed_q && !attached && |dev_type_q && !is_button;
    assign ev_set[`AIDSC_EV_BUTTON] = changed_q && is_button;
    assign ev_set[`AIDSC_EV_CHANGE] = changed_q;
    // Level interrupt: stays low until the event register is read
    assign irq_n_out = ~(|event_q & ~irq_mask_q);

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            code_q       <= `AIDSC_CODE_OPEN;
            changed_q    <= 1'b0;
            state_q      <= ST_IDLE;
            dev_type_q   <= 13'h0000;
            event_q      <= 4'h0;
            irq_mask_q   <= 1'b0;
            manual_q     <= 1'b0;
            wait_units_q <= `AIDSC_WAIT_RESET;
            man_route_q  <= `AIDSC_RT_OPEN;
            unit_cnt_q   <= 8'h00;
            div_cnt_q    <= 16'h0000;
            lvl_q        <= 3'h0;
        end else begin
            code_q    <= code_s_q;
            lvl_q     <= lvl_s_q;
            changed_q <= code_chg || lvl_chg;
            // Set beats the read-to-clear in the same cycle
            event_q   <= (rd_event ? 4'h0 : event_q) | ev_set;
            div_cnt_q <= unit_tick ? 16'h0000 : div_cnt_q + 16'h0001;
            if (changed_q && !is_button)
                dev_type_q <= type_now;
            if (reg_wr_in) begin
                case (reg_addr_in)
                    `AIDSC_REG_CTRL: begin
                        irq_mask_q <= reg_wdata_in[0];
                        manual_q   <= reg_wdata_in[1];
                    end
                    `AIDSC_REG_WAIT:   wait_units_q <= reg_wdata_in[7:0];
                    `AIDSC_REG_SWITCH: man_route_q  <= reg_wdata_in[2:0];
                    default: ;
                endcase
            end
            case (state_q)
                ST_IDLE: if (changed_q && attached && !is_button)
                    state_q <= is_fact ? ST_CONF : ST_ACK;
                ST_ACK: if (rd_event) begin
                    state_q    <= ST_WAIT;
                    unit_cnt_q <= 8'h00;
                end
                // Free-running tick: the first unit may be short by up to one unit
                ST_WAIT: if (unit_cnt_q >= wait_units_q) state_q <= ST_CONF;
                    else if (unit_tick) unit_cnt_q <= unit_cnt_q + 8'h01;
                ST_CONF: ;
                default: state_q <= ST_IDLE;
            endcase
            // New accessory or detach restarts the sequence
            if (changed_q && !is_button && state_q != ST_IDLE)
                state_q <= !attached ? ST_IDLE : (is_fact ? ST_CONF : ST_ACK);
        end
    end

    // ************************************************
    // Register read port
    // ************************************************
    // Read data stand one cycle after the strobe, zero otherwise
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `AIDSC_REG_ADC:     reg_rdata_out <= {11'h000, code_q};
                `AIDSC_REG_DEVTYPE: reg_rdata_out <= {3'h0, dev_type_q};
                `AIDSC_REG_EVENT:   reg_rdata_out <= {12'h000, event_q};
                `AIDSC_REG_CTRL:    reg_rdata_out <= {10'h000, state_q, manual_q, irq_mask_q};
                `AIDSC_REG_WAIT:    reg_rdata_out <= {8'h00, wait_units_q};
                `AIDSC_REG_SWITCH:  reg_rdata_out <= {13'h0000, man_route_q};
                default:            reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    // ************************************************
    // Switch configuration outputs
    // ************************************************
    reg [2:0] rt_d;
    reg [1:0] sn_d;
    reg       mic_d, fet_d, sel_d, jig_d, chg_d;
    wire      conf = (state_q == ST_CONF);
    always @* begin
        rt_d  = `AIDSC_RT_OPEN;
        sn_d  = `AIDSC_SN_MONITOR;
        mic_d = 1'b0;
        fet_d = 1'b0;
        sel_d = 1'b0;
        jig_d = 1'b0;
        chg_d = 1'b0;
        if (conf) begin
            if (dev_type_q[`AIDSC_DT_AUDIO1]) begin
                rt_d = `AIDSC_RT_AUDIO;
                mic_d = 1'b1;
            end
            if (dev_type_q[`AIDSC_DT_AUDIO2]) begin
                rt_d = `AIDSC_RT_SERIAL;
                fet_d = 1'b1;
            end
            if (dev_type_q[`AIDSC_DT_TTY]) begin
                rt_d = `AIDSC_RT_TTY;
                mic_d = 1'b1;
            end
            if (dev_type_q[`AIDSC_DT_SERIAL]) begin
                rt_d = `AIDSC_RT_SERIAL;
                fet_d = vbus_s;
            end
            // Phone-powered device: supply path only closes after the wait
            if (dev_type_q[`AIDSC_DT_PPD]) begin
                rt_d = `AIDSC_RT_AUDIO;
                fet_d = 1'b1;
            end
            if (dev_type_q[`AIDSC_DT_AV]) begin
                rt_d = `AIDSC_RT_VIDEO;
                sn_d = `AIDSC_SN_VIDEO;
                fet_d = vbus_s;
                chg_d = vbus_s;
            end
            if (dev_type_q[`AIDSC_DT_USB] || dev_type_q[`AIDSC_DT_USBCHG] || dev_type_q[`AIDSC_DT_OTG]) begin
                rt_d = `AIDSC_RT_HOST;
                sn_d = `AIDSC_SN_BYPASS;
                fet_d = 1'b1;
            end
            if (dev_type_q[`AIDSC_DT_DEDCHG] || dev_type_q[`AIDSC_DT_CHARGER])
                fet_d = 1'b1;
            if (dev_type_q[`AIDSC_DT_USBCHG] || dev_type_q[`AIDSC_DT_DEDCHG] || dev_type_q[`AIDSC_DT_CHARGER])
                chg_d = 1'b1;
            if (dev_type_q[`AIDSC_DT_FACTORY]) begin
                jig_d = 1'b1;
                sel_d = code_q[0];
                rt_d  = code_q[2] ? `AIDSC_RT_SERIAL : `AIDSC_RT_HOST;
                fet_d = ~code_q[2];
            end
            if (manual_q)
                rt_d = man_route_q;
        end
    end

    // Open-drain pins: level fixed low, only the enable moves
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            data_route_out              <= `AIDSC_RT_OPEN;
            sense_route_out             <= `AIDSC_SN_MONITOR;
            voice_input_path_out        <= 1'b0;
            fet_closed_out              <= 1'b0;
            startup_select_out          <= 1'b0;
            factory_pwr_o_out           <= 1'b0;
            factory_pwr_oe_n_out        <= 1'b1;
            charge_rate_signal_o_out    <= 1'b0;
            charge_rate_signal_oe_n_out <= 1'b1;
        end else begin
            data_route_out              <= rt_d;
            sense_route_out             <= sn_d;
            voice_input_path_out        <= mic_d;
            fet_closed_out              <= fet_d;
            startup_select_out          <= sel_d;
            factory_pwr_o_out           <= 1'b0;
            factory_pwr_oe_n_out        <= ~jig_d;
            charge_rate_signal_o_out    <= 1'b0;
            charge_rate_signal_oe_n_out <= ~chg_d;
        end
    end
endmodule
`default_nettype wire

// ===== src/aidsc_consts.vh
// Constants for the accessory sense decode and switch configuration block
`ifndef AIDSC_CONSTS_VH
`define AIDSC_CONSTS_VH
// Register offsets (word index on the plain register port)
`define AIDSC_REG_ADC       4'h0
`define AIDSC_REG_DEVTYPE   4'h1
`define AIDSC_REG_EVENT     4'h2
`define AIDSC_REG_CTRL      4'h3
`define AIDSC_REG_WAIT      4'h4
`define AIDSC_REG_SWITCH    4'h5
// Converter codes
`define AIDSC_CODE_OTG      5'h00
`define AIDSC_CODE_SENDEND  5'h01
`define AIDSC_CODE_BTN_LO   5'h02
`define AIDSC_CODE_BTN_HI   5'h0D
`define AIDSC_CODE_RSV_LO   5'h0E
`define AIDSC_CODE_RSV_HI   5'h12
`define AIDSC_CODE_AUDIO2   5'h13
`define AIDSC_CODE_PPD      5'h14
`define AIDSC_CODE_TTY      5'h15
`define AIDSC_CODE_SERIAL   5'h16
`define AIDSC_CODE_CHG1     5'h17
`define AIDSC_CODE_FUSB_OFF 5'h18
`define AIDSC_CODE_FUSB_ON  5'h19
`define AIDSC_CODE_AV       5'h1A
`define AIDSC_CODE_CHG2     5'h1B
`define AIDSC_CODE_FSER_OFF 5'h1C
`define AIDSC_CODE_FSER_ON  5'h1D
`define AIDSC_CODE_AUDIO1   5'h1E
`define AIDSC_CODE_OPEN     5'h1F
// Device type flag bits
`define AIDSC_DT_OTG        0
`define AIDSC_DT_AUDIO1     1
`define AIDSC_DT_AUDIO2     2
`define AIDSC_DT_PPD        3
`define AIDSC_DT_TTY        4
`define AIDSC_DT_SERIAL     5
`define AIDSC_DT_CHARGER    6
`define AIDSC_DT_FACTORY    7
`define AIDSC_DT_AV         8
`define AIDSC_DT_USB        9
`define AIDSC_DT_DEDCHG     10
`define AIDSC_DT_USBCHG     11
`define AIDSC_DT_RESERVED   12
// Event flag bits
`define AIDSC_EV_ATTACH     0
`define AIDSC_EV_DETACH     1
`define AIDSC_EV_BUTTON     2
`define AIDSC_EV_CHANGE     3
// Data-line routes
`define AIDSC_RT_OPEN       3'h0
`define AIDSC_RT_HOST       3'h1
`define AIDSC_RT_AUDIO      3'h2
`define AIDSC_RT_SERIAL     3'h3
`define AIDSC_RT_VIDEO      3'h4
`define AIDSC_RT_TTY        3'h5
// Sense pin routes
`define AIDSC_SN_MONITOR    2'h0
`define AIDSC_SN_BYPASS     2'h1
`define AIDSC_SN_VIDEO      2'h2
// Wait timer
`define AIDSC_WAIT_UNIT_US  10
`define AIDSC_WAIT_UNIT_CYC (`AIDSC_WAIT_UNIT_US * 50)
`define AIDSC_WAIT_RESET    8'h0A
`endif

// ===== tb/aidsc_accessory.sv
// Accessory model driving the sense converter and supply lines
`default_nettype none
module aidsc_accessory (
    input  wire logic       mclk_in,
    output var  logic [4:0] sense_code_out,
    output var  logic       vbus_valid_out,
    output var  logic       usb_charger_out,
    output var  logic       ded_charger_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sense_code_out = 5'h1F;
        vbus_valid_out = 1'b0;
        usb_charger_out = 1'b0;
        ded_charger_out = 1'b0;
    end
    // Charger detect only answers on an open sense pin
    task automatic plug(input logic [4:0] c, input logic vb, input logic uc, input logic dc);
        @(posedge mclk_in);
        sense_code_out <= c;
        vbus_valid_out <= vb;
        usb_charger_out <= uc && c == 5'h1F;
        ded_charger_out <= dc && c == 5'h1F;
    endtask
endmodule
`default_nettype wire

// ===== tb/aidsc_top_props.sv
// Port checker for the accessory decode block
`default_nettype none
module aidsc_top_props (
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic [4:0]  sense_code_in,
    input wire logic        vbus_valid_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        irq_n_out,
    input wire logic [2:0]  data_route_out,
    input wire logic        fet_closed_out,
    input wire logic        startup_select_out,
    input wire logic        factory_pwr_oe_n_out,
    input wire logic        charge_rate_signal_oe_n_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // Eight samples cover the synchroniser and decode latency
    sequence s_quiet;
        ($stable(sense_code_in) && $stable(vbus_valid_in)) [*8];
    endsequence
    property p_rd_idle; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
    property p_rd_unmap; reg_rd_in && reg_addr_in > 4'h5 |=> reg_rdata_out == 16'h0000; endproperty
    property p_mask; reg_wr_in && reg_addr_in == 4'h3 && reg_wdata_in[0] |=> irq_n_out; endproperty
    property p_ack; s_quiet ##0 (reg_rd_in && reg_addr_in == 4'h2) |=> irq_n_out; endproperty
    property p_sel; startup_select_out |-> !factory_pwr_oe_n_out; endproperty
    property p_chg; !charge_rate_signal_oe_n_out |-> fet_closed_out; endproperty
    property p_fser; !factory_pwr_oe_n_out && data_route_out == 3'h3 |-> !fet_closed_out; endproperty
    property p_fusb;
        sense_code_in == 5'h19 [*8] |=> startup_select_out && !factory_pwr_oe_n_out && fet_closed_out;
    endproperty
    property p_fsoff;
        sense_code_in == 5'h1C [*8] |=> !startup_select_out && !factory_pwr_oe_n_out && data_route_out == 3'h3;
    endproperty
    property p_gone;
        (sense_code_in == 5'h1F && !vbus_valid_in) [*8] |=> factory_pwr_oe_n_out && charge_rate_signal_oe_n_out;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    a_mask: assert property (p_mask) else $error("masked interrupt still low");
    a_ack: assert property (p_ack) else $error("interrupt kept after event read");
    a_sel: assert property (p_sel) else $error("startup select outside factory");
    a_chg: assert property (p_chg) else $error("charge rate low with fet open");
    a_fser: assert property (p_fser) else $error("factory serial with fet closed");
    a_fusb: assert property (p_fusb) else $error("factory usb boot on not set");
    a_fsoff: assert property (p_fsoff) else $error("factory serial boot off not set");
    a_gone: assert property (p_gone) else $error("detach left lines driven");
    c_audio: cover property (sense_code_in == 5'h1E [*8]);
    c_chg: cover property (!charge_rate_signal_oe_n_out);
    c_video: cover property (data_route_out == 3'h4);
endmodule
bind aidsc_top aidsc_top_props i_aidsc_top_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .sense_code_in(sense_code_in), .vbus_valid_in(vbus_valid_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .irq_n_out(irq_n_out), .data_route_out(data_route_out),
    .fet_closed_out(fet_closed_out), .startup_select_out(startup_select_out),
    .factory_pwr_oe_n_out(factory_pwr_oe_n_out), .charge_rate_signal_oe_n_out(charge_rate_signal_oe_n_out));
`default_nettype wire

// ===== tb/aidsc_top_tb.sv
// Self-checking bench for the accessory decode block
`default_nettype none
`include "aidsc_consts.vh"
module aidsc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] v;
    wire  [15:0] rdata;
    wire  [4:0]  code;
    wire  [2:0]  route;
    wire  [1:0]  sroute;
    wire         vb, uc, dc, irq_n, voice, fet, sel, pwr_o, pwr_oe_n, chg_o, chg_oe_n;
    int          miscompares = 0;
    int          checked = 0;
    int          cyc = 0;
    always #10 clk = ~clk;
    aidsc_accessory i_aidsc_accessory (.mclk_in(clk), .sense_code_out(code), .vbus_valid_out(vb),
        .usb_charger_out(uc), .ded_charger_out(dc));
    aidsc_top i_aidsc_top (.mclk_in(clk), .rst_n_in(rst_n), .sense_code_in(code), .vbus_valid_in(vb),
        .usb_charger_in(uc), .ded_charger_in(dc), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_n_out(irq_n),
        .data_route_out(route), .sense_route_out(sroute), .voice_input_path_out(voice),
        .fet_closed_out(fet), .startup_select_out(sel), .factory_pwr_o_out(pwr_o),
        .factory_pwr_oe_n_out(pwr_oe_n), .charge_rate_signal_o_out(chg_o),
        .charge_rate_signal_oe_n_out(chg_oe_n));
    // ****
    // Bus cycles and comparison
    // ****
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Flags: voice, fet, select, power-up release, charge release, irq release
    task automatic outs(input logic [2:0] r, input logic [1:0] s, input logic [5:0] f);
        chk("outputs", {3'h0, route, sroute, voice, fet, sel, pwr_oe_n, chg_oe_n, irq_n, pwr_o, chg_o},
            {3'h0, r, s, f, 2'b00});
    endtask
    task automatic classify(input logic [4:0] c, input logic vbv, input logic [15:0] e);
        i_aidsc_accessory.plug(c, vbv, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        rd_reg(`AIDSC_REG_DEVTYPE, v);
        chk("device type", v, e);
        rd_reg(`AIDSC_REG_EVENT, v);
        repeat (4) @(posedge clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        outs(`AIDSC_RT_OPEN, `AIDSC_SN_MONITOR, 6'b000111);
        rd_reg(`AIDSC_REG_WAIT, v);
        chk("wait units", v, 16'h000A);
        wr_reg(`AIDSC_REG_ADC, 16'h0005);
        rd_reg(`AIDSC_REG_ADC, v);
        chk("converter code", v, 16'h001F);
        rd_reg(4'hF, v);
        chk("unmapped", v, 16'h0000);
        wr_reg(`AIDSC_REG_WAIT, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_factory();
        logic [4:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i < 2 ? 5'h18 + 5'(i) : 5'h1A + 5'(i);
            i_aidsc_accessory.plug(c, 1'b0, 1'b0, 1'b0);
            repeat (10) @(posedge clk);
            outs(c < 5'h1C ? `AIDSC_RT_HOST : `AIDSC_RT_SERIAL, `AIDSC_SN_MONITOR,
                {1'b0, c < 5'h1C, c[0], 3'b010});
            rd_reg(`AIDSC_REG_EVENT, v);
            chk("attach", v & 16'h0003, 16'h0001);
            classify(5'h1F, 1'b0, 16'h0000);
            outs(`AIDSC_RT_OPEN, `AIDSC_SN_MONITOR, 6'b000111);
        end
        $display("test factory done");
    endtask
    task automatic t_audio();
        i_aidsc_accessory.plug(5'h1E, 1'b0, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        outs(`AIDSC_RT_OPEN, `AIDSC_SN_MONITOR, 6'b000110);
        wr_reg(`AIDSC_REG_CTRL, 16'h0001);
        #1 chk("masked irq", {15'h0, irq_n}, 16'h0001);
        wr_reg(`AIDSC_REG_CTRL, 16'h0000);
        rd_reg(`AIDSC_REG_ADC, v);
        chk("converter code", v, 16'h001E);
        classify(5'h1E, 1'b0, 16'h0002);
        outs(`AIDSC_RT_AUDIO, `AIDSC_SN_MONITOR, 6'b100111);
        for (int b = 1; b < 14; b++) begin
            i_aidsc_accessory.plug(5'(b), 1'b0, 1'b0, 1'b0);
            repeat (10) @(posedge clk);
            rd_reg(`AIDSC_REG_EVENT, v);
            chk("button", v & 16'h0004, 16'h0004);
        end
        classify(5'h1E, 1'b0, 16'h0002);
        classify(5'h1F, 1'b0, 16'h0000);
        $display("test audio done");
    endtask
    task automatic t_classes();
        classify(5'h00, 1'b0, 16'h0001);
        classify(5'h1F, 1'b0, 16'h0000);
        for (int c = 14; c < 23; c++) begin
            classify(5'(c), 1'b0, 16'h1 << (c < 19 ? 12 : c - 17));
            classify(5'h1F, 1'b0, 16'h0000);
        end
        classify(5'h17, 1'b0, 16'h0000);
        classify(5'h17, 1'b1, 16'h0040);
        classify(5'h1F, 1'b0, 16'h0000);
        $display("test classes done");
    endtask
    task automatic t_usb();
        // Two wait units keep the switches open for at least one full unit
        wr_reg(`AIDSC_REG_WAIT, 16'h0002);
        i_aidsc_accessory.plug(5'h1F, 1'b1, 1'b1, 1'b0);
        repeat (10) @(posedge clk);
        rd_reg(`AIDSC_REG_DEVTYPE, v);
        chk("device type", v, 16'h0800);
        rd_reg(`AIDSC_REG_EVENT, v);
        chk("attach", v & 16'h0003, 16'h0001);
        outs(`AIDSC_RT_OPEN, `AIDSC_SN_MONITOR, 6'b000111);
        repeat (1100) @(posedge clk);
        outs(`AIDSC_RT_HOST, `AIDSC_SN_BYPASS, 6'b010101);
        wr_reg(`AIDSC_REG_WAIT, 16'h0000);
        i_aidsc_accessory.plug(5'h1F, 1'b1, 1'b0, 1'b1);
        repeat (10) @(posedge clk);
        rd_reg(`AIDSC_REG_DEVTYPE, v);
        chk("device type", v, 16'h0400);
        rd_reg(`AIDSC_REG_EVENT, v);
        repeat (4) @(posedge clk);
        outs(`AIDSC_RT_OPEN, `AIDSC_SN_MONITOR, 6'b010101);
        classify(5'h1F, 1'b0, 16'h0000);
        classify(5'h1A, 1'b0, 16'h0100);
        outs(`AIDSC_RT_VIDEO, `AIDSC_SN_VIDEO, 6'b000111);
        classify(5'h1A, 1'b1, 16'h0100);
        outs(`AIDSC_RT_VIDEO, `AIDSC_SN_VIDEO, 6'b010101);
        classify(5'h1F, 1'b0, 16'h0000);
        $display("test usb and video done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_factory();
        t_audio();
        t_classes();
        t_usb();
        close_out();
    end
endmodule
`default_nettype wire
